// ---- host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// host side: start pin and serial reader, sclk idles high
module host_model (
  input wire logic aclk, // clock
  output logic conversion_start_n, // start pin
  output logic cs_n, // chip select
  output logic sclk, // serial clock
  input wire logic da, // data a
  input wire logic db // data b
);
  initial begin
    conversion_start_n = 1'b1;
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  task automatic pin(input logic v);
    @(posedge aclk) conversion_start_n <= v;
  endtask
  // one 800 ns sclk period per bit, both lines together
  task automatic frame(output logic [13:0] a, output logic [13:0] b);
    @(posedge aclk) cs_n <= 1'b0;
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 14; i++) begin
      @(negedge aclk);
      a = {a[12:0], da};
      b = {b[12:0], db};
      @(posedge aclk) sclk <= 1'b0;
      repeat (4) @(posedge aclk);
      sclk <= 1'b1;
      repeat (3) @(posedge aclk);
    end
    @(posedge aclk) cs_n <= 1'b1;
  endtask
endmodule // host_model
`default_nettype wire

// ---- sar_ctl.v ----
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctl_defines.vh"
module sar_ctl (
  input wire aclk, // 10 MHz clock
  input wire aresetn, // sync reset, active low
  input wire conversion_start_n, // start pin, falling edge
  input wire sclk, // serial clock pin
  input wire cs_n, // chip select pin
  input wire reference_source_select, // 1 internal ref
  input wire input_range_sel0, // range pin 0
  input wire input_range_sel1, // range pin 1
  input wire chan_pair_sel, // channel pair pin
  input wire [13:0] sample_a, // digitised input a
  input wire [13:0] sample_b, // digitised input b
  output reg busy, // conversion busy
  output reg hold, // track-holds in hold
  output reg power_down, // power-down state
  output reg use_internal_ref, // internal reference on
  output reg [1:0] range_code, // applied range
  output reg chan_pair, // applied channel pair
  output reg serial_result_a, // data out a
  output reg serial_result_a_oe_n, // enable a, low drives
  output reg serial_result_b, // data out b
  output reg serial_result_b_oe_n, // enable b, low drives
  output reg irq, // interrupt level
  input wire [7:0] s_axi_awaddr, // axi write addr
  input wire s_axi_awvalid, // axi
  output reg s_axi_awready, // axi
  input wire [31:0] s_axi_wdata, // axi
  input wire [3:0] s_axi_wstrb, // axi
  input wire s_axi_wvalid, // axi
  output reg s_axi_wready, // axi
  output reg [1:0] s_axi_bresp, // axi
  output reg s_axi_bvalid, // axi
  input wire s_axi_bready, // axi
  input wire [7:0] s_axi_araddr, // axi
  input wire s_axi_arvalid, // axi
  output reg s_axi_arready, // axi
  output reg [31:0] s_axi_rdata, // axi
  output reg [1:0] s_axi_rresp, // axi
  output reg s_axi_rvalid, // axi
  input wire s_axi_rready // axi
);
  // ==========================================
  // pin synchronisers
  wire cnv_s, sclk_s, cs_s, ref_s, r0_s, r1_s, addr_s;
  // reset level of each stage is the pin's idle level, so no false edge follows reset
  sync2 u_cnv (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(conversion_start_n),
    .init(1'b1),
    .q(cnv_s)
  );
  sync2 u_sck (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sclk),
    .init(1'b1),
    .q(sclk_s)
  );
  sync2 u_cs (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(cs_n),
    .init(1'b1),
    .q(cs_s)
  );
  sync2 u_ref (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(reference_source_select),
    .init(1'b0),
    .q(ref_s)
  );
  sync2 u_r0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(input_range_sel0),
    .init(1'b0),
    .q(r0_s)
  );
  sync2 u_r1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(input_range_sel1),
    .init(1'b0),
    .q(r1_s)
  );
  sync2 u_adr (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(chan_pair_sel),
    .init(1'b0),
    .q(addr_s)
  );
  reg cnv_d_r, sclk_d_r, cs_d_r, primed_r;
  // primed_r keeps the first compare after reset from reading as an edge
  wire cnv_fall = primed_r & cnv_d_r & ~cnv_s;
  wire cnv_rise = primed_r & ~cnv_d_r & cnv_s;
  wire sclk_fall = sclk_d_r & ~sclk_s;
  wire cs_fall = cs_d_r & ~cs_s;
  // ==========================================
  // control register and internal oscillator
  reg [31:0] ctrl_r;
  wire wide = ~ctrl_r[0]; // bit0 set selects 12-bit variant
  reg [3:0] osc_r;
  // free-running divider stands in for the internal oscillator
  wire osc_tick = (osc_r == `OSC_DIV);
  always @(posedge aclk) begin
    if (!aresetn) osc_r <= 4'h0;
    else osc_r <= osc_tick ? 4'h0 : osc_r + 4'h1;
  end
  // ==========================================
  // two converters started together
  wire start = cnv_fall & ~busy & ~power_down;
  wire ba, bb;
  wire [13:0] code_a, code_b;
  // track-and-hold model: both inputs frozen on the one start edge
  reg [13:0] held_a_r, held_b_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      held_a_r <= 14'h0000;
      held_b_r <= 14'h0000;
    end else if (start) begin
      held_a_r <= sample_a;
      held_b_r <= sample_b;
    end
  end
  sar_engine u_ea (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_tick(osc_tick),
    .start(start),
    .wide(wide),
    .sample(held_a_r),
    .busy_o(ba),
    .code(code_a)
  );
  sar_engine u_eb (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_tick(osc_tick),
    .start(start),
    .wide(wide),
    .sample(held_b_r),
    .busy_o(bb),
    .code(code_b)
  );
  // done only once both engines have stopped, never on the start edge itself
  wire conv_done = busy & ~ba & ~bb & ~start;
  // result as kept: the 12-bit variant clears the two top bits
  function [13:0] trim;
    input [13:0] c;
    input w;
    begin
      trim = w ? c : {2'b00, c[11:0]};
    end
  endfunction
  // shift word: msb of the active width sits at bit 13
  function [13:0] left_align;
    input [13:0] c;
    input w;
    begin
      left_align = w ? c : {c[11:0], 2'b00};
    end
  endfunction
  reg [13:0] res_a_r, res_b_r, sh_a_r, sh_b_r;
  reg bad_range_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnv_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      primed_r <= 1'b0;
      busy <= 1'b0;
      hold <= 1'b0;
      power_down <= 1'b0;
      use_internal_ref <= 1'b0;
      range_code <= 2'b00;
      chan_pair <= 1'b0;
      res_a_r <= 14'h0000;
      res_b_r <= 14'h0000;
      bad_range_r <= 1'b0;
    end else begin
      cnv_d_r <= cnv_s;
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
      primed_r <= 1'b1;
      use_internal_ref <= ref_s;
      bad_range_r <= 1'b0;
      if (start) begin
        hold <= 1'b1;
        busy <= 1'b1;
        chan_pair <= addr_s;
        if (r0_s & r1_s) bad_range_r <= 1'b1;
        else range_code <= {r1_s, r0_s};
      end else if (conv_done) begin
        busy <= 1'b0;
        hold <= 1'b0;
        res_a_r <= trim(code_a, wide);
        res_b_r <= trim(code_b, wide);
        // start pin still low here parks the part until the pin rises again
        if (!cnv_s) power_down <= 1'b1;
      end
      if (power_down && cnv_rise) power_down <= 1'b0;
    end
  end
  // ==========================================
  // serial readout
  // bits advance on the falling sclk edge, the host samples while sclk is high
  always @(posedge aclk) begin
    if (!aresetn) begin
      sh_a_r <= 14'h0000;
      sh_b_r <= 14'h0000;
      serial_result_a <= 1'b0;
      serial_result_b <= 1'b0;
      serial_result_a_oe_n <= 1'b1;
      serial_result_b_oe_n <= 1'b1;
    end else begin
      serial_result_a_oe_n <= cs_s;
      serial_result_b_oe_n <= cs_s;
      if (cs_fall && !busy) begin
        sh_a_r <= left_align(res_a_r, wide);
        sh_b_r <= left_align(res_b_r, wide);
        serial_result_a <= wide ? res_a_r[13] : res_a_r[11];
        serial_result_b <= wide ? res_b_r[13] : res_b_r[11];
      end else if (!cs_s && sclk_fall && !busy) begin
        sh_a_r <= {sh_a_r[12:0], 1'b0};
        sh_b_r <= {sh_b_r[12:0], 1'b0};
        serial_result_a <= sh_a_r[12];
        serial_result_b <= sh_b_r[12];
      end
    end
  end
  // ==========================================
  // interrupt status and mask
  reg [2:0] istat_r, imask_r;
  // one-cycle event strobes, one per status bit
  wire [2:0] ev;
  assign ev[`IRQ_DONE] = conv_done;
  assign ev[`IRQ_BADRANGE] = bad_range_r;
  assign ev[`IRQ_PDOWN] = conv_done & ~cnv_s;
  // ==========================================
  // axi4-lite slave
  reg [7:0] awa_r;
  reg aw_h_r, w_h_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  wire do_wr = aw_h_r & w_h_r & ~s_axi_bvalid;
  // a one written to a status bit clears it; an event in the same cycle wins
  wire [2:0] w1c_clr = (do_wr && awa_r == `OFS_IRQ_STAT && ws_r[0]) ? wd_r[2:0] : 3'h0;
  wire [2:0] istat_nxt = (istat_r & ~w1c_clr) | ev;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      ctrl_r <= `CTRL_RESET;
      istat_r <= 3'h0;
      imask_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awa_r <= s_axi_awaddr;
        aw_h_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        w_h_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (awa_r)
          `OFS_CTRL: ctrl_r <= merge(ctrl_r, wd_r, ws_r);
          `OFS_IRQ_MASK: if (ws_r[0]) imask_r <= wd_r[2:0];
          `OFS_IRQ_STAT, `OFS_STATUS, `OFS_RESULT_A, `OFS_RESULT_B, `OFS_SAMPLE_A, `OFS_SAMPLE_B: ;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      istat_r <= istat_nxt;
      // a set mask bit silences its status bit
      irq <= |(istat_nxt & ~imask_r);
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= ctrl_r;
        `OFS_STATUS: s_axi_rdata <= {24'h0, 1'b0, range_code, chan_pair, use_internal_ref,
          power_down, hold, busy};
        `OFS_IRQ_STAT: s_axi_rdata <= {29'h0, istat_r};
        `OFS_IRQ_MASK: s_axi_rdata <= {29'h0, imask_r};
        `OFS_RESULT_A: s_axi_rdata <= {18'h0, res_a_r};
        `OFS_RESULT_B: s_axi_rdata <= {18'h0, res_b_r};
        `OFS_SAMPLE_A: s_axi_rdata <= {18'h0, held_a_r};
        `OFS_SAMPLE_B: s_axi_rdata <= {18'h0, held_b_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // sar_ctl
`default_nettype wire

// ---- sar_ctl_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// conversion and serial enable checks
module sar_ctl_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic conversion_start_n, // start pin
  input wire logic cs_n, // chip select
  input wire logic reference_source_select, // ref pin
  input wire logic busy, // converting
  input wire logic hold, // track-holds held
  input wire logic power_down, // power-down
  input wire logic use_internal_ref, // ref in use
  input wire logic serial_result_a_oe_n, // enable a
  input wire logic serial_result_b_oe_n // enable b
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_go;
    $fell(conversion_start_n) && !busy && !power_down;
  endsequence
  sequence s_end;
    $fell(busy);
  endsequence
  property p_start; s_go |-> ##[2:6] (busy && hold); endproperty
  a_start: assert property (p_start) else $error("start edge did not hold and convert");
  property p_busy_min; $rose(busy) |-> busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy dropped too early");
  property p_done; $rose(busy) |-> ##[20:40] s_end; endproperty
  a_done: assert property (p_done) else $error("conversion did not finish in time");
  property p_track; s_end |-> !hold; endproperty
  a_track: assert property (p_track) else $error("still in hold after busy fell");
  property p_oe_on; $fell(cs_n) |-> ##[1:4] !(serial_result_a_oe_n || serial_result_b_oe_n); endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not enabled after select");
  property p_oe_off; cs_n [*5] |-> serial_result_a_oe_n && serial_result_b_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while deselected");
  property p_ref; $stable(reference_source_select) [*6] |-> use_internal_ref == reference_source_select; endproperty
  a_ref: assert property (p_ref) else $error("reference choice does not follow pin");
  property p_pd_in; $rose(power_down) |-> !conversion_start_n; endproperty
  a_pd_in: assert property (p_pd_in) else $error("power-down with start pin high");
  property p_pd_out; power_down && $rose(conversion_start_n) |-> ##[1:6] !power_down; endproperty
  a_pd_out: assert property (p_pd_out) else $error("no wake on start rising");
endmodule // sar_ctl_chk
bind sar_ctl sar_ctl_chk i_chk (.aclk, .aresetn, .conversion_start_n, .cs_n, .reference_source_select, .busy,
  .hold, .power_down, .use_internal_ref, .serial_result_a_oe_n, .serial_result_b_oe_n);
`default_nettype wire

// ---- sar_ctl_defines.vh ----
`ifndef SAR_CTL_DEFINES_VH
`define SAR_CTL_DEFINES_VH
`define RES_BITS 14
`define OSC_DIV 4'h1
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_RESULT_A 8'h10
`define OFS_RESULT_B 8'h14
`define OFS_SAMPLE_A 8'h18
`define OFS_SAMPLE_B 8'h1c
`define CTRL_RESET 32'h0000_0000
`define IRQ_DONE 0
`define IRQ_BADRANGE 1
`define IRQ_PDOWN 2
`endif

// ---- sar_ctl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module sar_ctl_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic reference_source_select = 1'b1; // fixed from power-up
  logic input_range_sel0 = 1'b0, input_range_sel1 = 1'b0, chan_pair_sel = 1'b0;
  logic [13:0] sample_a = 14'h0000, sample_b = 14'h0000, qa, qb;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] r;
  wire conversion_start_n, sclk, cs_n, busy, hold, power_down, use_internal_ref, chan_pair, irq;
  wire serial_result_a, serial_result_a_oe_n, serial_result_b, serial_result_b_oe_n;
  wire [1:0] range_code, s_axi_bresp, s_axi_rresp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [31:0] s_axi_rdata;
  int err_count = 0, n_compared = 0;
  always #50 aclk = ~aclk;
  sar_ctl i_sar_ctl (.aclk, .aresetn, .conversion_start_n, .sclk, .cs_n, .reference_source_select,
    .input_range_sel0, .input_range_sel1, .chan_pair_sel, .sample_a, .sample_b, .busy, .hold, .power_down,
    .use_internal_ref, .range_code, .chan_pair, .serial_result_a, .serial_result_a_oe_n, .serial_result_b,
    .serial_result_b_oe_n, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  host_model i_host (.aclk, .conversion_start_n, .cs_n, .sclk, .da(serial_result_a), .db(serial_result_b));
  // ====
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rdata", d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ====
  // tests
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("pair_default", chan_pair, 0);
    chk("int_ref", use_internal_ref, 1);
    rc(8'h00, 32'h0, 2'b00);
    rc(8'h40, 32'h0, 2'b10);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        wr(8'h00, 32'h1);
        rc(8'h00, 32'h1, 2'b00);
      end
      @(posedge aclk);
      {input_range_sel1, input_range_sel0} <= k[1:0];
      chan_pair_sel <= k[0];
      sample_a <= (k == 4) ? 14'h0a5c : 14'h2a5c + k[13:0];
      sample_b <= (k == 4) ? 14'h05a3 : 14'h15a3 - k[13:0];
      repeat (4) @(posedge aclk); // pins settle before the start
      i_host.pin(1'b0);
      repeat (5) @(posedge aclk);
      i_host.pin(1'b1);
      chk("busy", busy, 1);
      for (int i = 0; i < 80 && busy !== 1'b0; i++) @(posedge aclk);
      chk("hold", hold, 0);
      chk("range", range_code, k == 3 ? 2 : k % 4);
      chk("pair", chan_pair, k[0]);
      i_host.frame(qa, qb);
      chk("res_a", k == 4 ? {2'b00, qa[13:2]} : qa, k == 4 ? {2'b00, sample_a[11:0]} : sample_a);
      chk("res_b", k == 4 ? {2'b00, qb[13:2]} : qb, k == 4 ? {2'b00, sample_b[11:0]} : sample_b);
    end
    rc(8'h08, 32'h3, 2'b00);
    chk("irq", irq, 1);
    wr(8'h0c, 32'h7);
    repeat (2) @(posedge aclk);
    chk("irq_masked", irq, 0);
    wr(8'h0c, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_unmasked", irq, 1);
    wr(8'h08, 32'h3);
    repeat (2) @(posedge aclk);
    chk("irq_clr", irq, 0);
    i_host.pin(1'b0);
    repeat (60) @(posedge aclk);
    chk("pd", power_down, 1);
    i_host.pin(1'b1);
    repeat (8) @(posedge aclk);
    chk("pd_exit", power_down, 0);
    rc(8'h08, 32'h5, 2'b00);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish;
  end
endmodule // sar_ctl_tb
`default_nettype wire

// ---- sar_engine.v ----
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctl_defines.vh"
// bitwise successive approximation against a sample word
module sar_engine (
  input wire aclk, // clock
  input wire aresetn, // sync reset
  input wire osc_tick, // internal oscillator step
  input wire start, // start pulse
  input wire wide, // 14-bit variant when high
  input wire [13:0] sample, // held input value
  output reg busy_o, // converting
  output reg [13:0] code // result
);
  reg [3:0] bit_r;
  reg [13:0] trial;
  always @* begin
    trial = code | (14'h0001 << bit_r);
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_o <= 1'b0;
      bit_r <= 4'h0;
      code <= 14'h0000;
    end else if (start) begin
      busy_o <= 1'b1;
      code <= 14'h0000;
      bit_r <= wide ? 4'hd : 4'hb;
    end else if (busy_o && osc_tick) begin
      if (trial <= sample) code <= trial;
      if (bit_r == 4'h0) busy_o <= 1'b0;
      else bit_r <= bit_r - 4'h1;
    end
  end
endmodule // sar_engine
`default_nettype wire

// ---- sync2.v ----
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  input wire aclk, // clock
  input wire aresetn, // sync reset
  input wire d, // async input
  input wire init, // reset level
  output reg q // synced level
);
  reg s1_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= init;
      q <= init;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule // sync2
`default_nettype wire
